// file: rtl/gps_pkg.sv
package gps_pkg;

  localparam int ADDR_W = 8;

  // Register byte offsets, one aligned word each.
  localparam logic [ADDR_W-1:0] OFF_DIR   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PIN   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_LAT   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_ANSEL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_WPU   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_STEER = 8'h14;

  // Reset values, and the mask of implemented analog-select bits.
  localparam logic [7:0] DIR_RST   = 8'hff;
  localparam logic [7:0] LAT_RST   = 8'h00;
  localparam logic [7:0] ANSEL_RST = 8'h2f;
  localparam logic [7:0] ANSEL_IMP = 8'h2f;
  localparam logic [7:0] WPU_RST   = 8'h00;
  localparam logic [7:0] STEER_RST = 8'h00;

  // Steering bit positions.
  localparam int SEL_M1_PWM_B = 0;
  localparam int SEL_M1_PWM_C = 1;
  localparam int SEL_M2_CAP   = 2;
  localparam int SEL_M2_PWM_B = 3;
  localparam int SEL_M2_PWM_C = 4;
  localparam int SEL_M2_PWM_D = 5;
  localparam int SEL_M3_PWM_B = 6;
  localparam int SEL_M3_PWM_C = 7;

  // Pin number on port E (select 0) and port D (select 1), per function but 2 (capture: C1 or E7),
  // three bits per function, function 0 in the low bits.
  localparam logic [23:0] FUNC_PIN = {3'h3, 3'h4, 3'h0, 3'h1, 3'h2,
                                      3'h7, 3'h5, 3'h6};
  localparam int CAP_ALT_PIN = 7;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// file: rtl/gps_port_top.sv
`timescale 1ns/10ps

module gps_port_top
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  padAIn,
  output logic [7:0]       padAOut,
  output logic [7:0]       padAOe,
  output logic [7:0]       weakPullupA,
  output logic [7:0]       analogSelA,
  input  wire logic [7:0]  perAEn,
  input  wire logic [7:0]  perAVal,
  input  wire logic [7:0]  funcOut,
  input  wire logic [7:0]  funcOe,
  input  wire logic        padC1In,
  input  wire logic        padE7In,
  output logic [6:0]       ovrDEn,
  output logic [6:0]       ovrDVal,
  output logic [7:0]       ovrEEn,
  output logic [7:0]       ovrEVal,
  output logic             ovrC1En,
  output logic             ovrC1Val,
  output logic             captureIn
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  logic [7:0]  dirQ;
  logic [7:0]  latQ;
  logic [7:0]  anselQ;
  logic [7:0]  wpuQ;
  logic [7:0]  steerQ;
  logic [7:0]  padSync1Q;
  logic [7:0]  padSync2Q;
  logic [1:0]  capSync1Q;
  logic [1:0]  capSync2Q;
  logic [7:0]  pinRead;
  logic [7:0]  awAddrQ;
  logic [31:0] wDataQ;
  logic [3:0]  wStrbQ;
  logic        awGotQ;
  logic        wGotQ;
  logic        wrFire;
  logic [7:0]  rmwMask;
  logic [7:0]  rmwVal;
  logic [7:0]  dEn;
  logic [7:0]  dVal;
  logic [7:0]  eEn;
  logic [7:0]  eVal;
  logic        c1En;
  logic        c1Val;
  logic [2:0]  pinIdx;

  function automatic logic isMapped(input logic [7:0] addr);
    return addr == gps_pkg::OFF_DIR || addr == gps_pkg::OFF_PIN ||
           addr == gps_pkg::OFF_LAT || addr == gps_pkg::OFF_ANSEL ||
           addr == gps_pkg::OFF_WPU || addr == gps_pkg::OFF_STEER;
  endfunction

  // Pad levels cross into the clock domain through two flip-flops.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      padSync1Q <= 8'h00;
      padSync2Q <= 8'h00;
      capSync1Q <= 2'h0;
      capSync2Q <= 2'h0;
    end
    else
    begin
      padSync1Q <= padAIn;
      padSync2Q <= padSync1Q;
      capSync1Q <= {padE7In, padC1In};
      capSync2Q <= capSync1Q;
    end
  end

  // Analog pins have their input buffer off and read as zero.
  assign pinRead = padSync2Q & ~anselQ;

  // Write path: address and data are taken in either order.
  assign wrFire = awGotQ && wGotQ && !s_axi_bvalid;

  // Byte lane 1, when enabled, marks the bits that a port write addresses;
  // the other bits are refilled from the pins.
  assign rmwMask = wStrbQ[1] ? wDataQ[15:8] : 8'hff;
  assign rmwVal  = (pinRead & ~rmwMask) | (wDataQ[7:0] & rmwMask);

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      awGotQ        <= 1'b0;
      wGotQ         <= 1'b0;
      awAddrQ       <= 8'h00;
      wDataQ        <= 32'h0000_0000;
      wStrbQ        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= gps_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddrQ       <= s_axi_awaddr;
        awGotQ        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wDataQ       <= s_axi_wdata;
        wStrbQ       <= s_axi_wstrb;
        wGotQ        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wrFire)
      begin
        awGotQ       <= 1'b0;
        wGotQ        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isMapped(awAddrQ) ? gps_pkg::RESP_OKAY
                                          : gps_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Port registers.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dirQ   <= gps_pkg::DIR_RST;
      latQ   <= gps_pkg::LAT_RST;
      anselQ <= gps_pkg::ANSEL_RST;
      wpuQ   <= gps_pkg::WPU_RST;
      steerQ <= gps_pkg::STEER_RST;
    end
    else if (wrFire && wStrbQ[0])
    begin
      case (awAddrQ)
        gps_pkg::OFF_DIR:   dirQ   <= wDataQ[7:0];
        gps_pkg::OFF_PIN:   latQ   <= rmwVal;
        gps_pkg::OFF_LAT:   latQ   <= rmwVal;
        gps_pkg::OFF_ANSEL: anselQ <= wDataQ[7:0] & gps_pkg::ANSEL_IMP;
        gps_pkg::OFF_WPU:   wpuQ   <= wDataQ[7:0];
        gps_pkg::OFF_STEER: steerQ <= wDataQ[7:0];
        default:            steerQ <= steerQ;
      endcase
    end
  end

  // Read path: one read under way, answered the cycle after it is taken.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= gps_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= isMapped(s_axi_araddr) ? gps_pkg::RESP_OKAY
                                              : gps_pkg::RESP_SLVERR;
      case (s_axi_araddr)
        gps_pkg::OFF_DIR:   s_axi_rdata <= {24'h000000, dirQ};
        gps_pkg::OFF_PIN:   s_axi_rdata <= {24'h000000, pinRead};
        gps_pkg::OFF_LAT:   s_axi_rdata <= {24'h000000, latQ};
        gps_pkg::OFF_ANSEL: s_axi_rdata <= {24'h000000, anselQ};
        gps_pkg::OFF_WPU:   s_axi_rdata <= {24'h000000, wpuQ};
        gps_pkg::OFF_STEER: s_axi_rdata <= {24'h000000, steerQ};
        default:            s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // Port A drivers. A peripheral owns its pin over the latch, and analog
  // select is left out of the drive path on purpose.
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      padAOe      <= 8'h00;
      padAOut     <= 8'h00;
      weakPullupA <= 8'h00;
      analogSelA  <= gps_pkg::ANSEL_RST;
    end
    else
    begin
      padAOe      <= perAEn | ~dirQ;
      padAOut     <= (perAEn & perAVal) | (~perAEn & latQ);
      weakPullupA <= wpuQ;
      analogSelA  <= anselQ;
    end
  end

  // Each steered function drives exactly one pin; the other is untouched.
  always_comb
  begin
    dEn    = 8'h00;
    dVal   = 8'h00;
    eEn    = 8'h00;
    eVal   = 8'h00;
    c1En   = 1'b0;
    c1Val  = 1'b0;
    pinIdx = 3'h0;
    for (int f = 0; f < 8; f++)
    begin
      pinIdx = gps_pkg::FUNC_PIN[f*3 +: 3];
      if (f == gps_pkg::SEL_M2_CAP)
      begin
        if (steerQ[f])
        begin
          eEn[gps_pkg::CAP_ALT_PIN]  = funcOe[f];
          eVal[gps_pkg::CAP_ALT_PIN] = funcOut[f];
        end
        else
        begin
          c1En  = funcOe[f];
          c1Val = funcOut[f];
        end
      end
      else if (steerQ[f])
      begin
        dEn[pinIdx]  = funcOe[f];
        dVal[pinIdx] = funcOut[f];
      end
      else
      begin
        eEn[pinIdx]  = funcOe[f];
        eVal[pinIdx] = funcOut[f];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovrDEn    <= 7'h00;
      ovrDVal   <= 7'h00;
      ovrEEn    <= 8'h00;
      ovrEVal   <= 8'h00;
      ovrC1En   <= 1'b0;
      ovrC1Val  <= 1'b0;
      captureIn <= 1'b0;
    end
    else
    begin
      ovrDEn    <= dEn[6:0];
      ovrDVal   <= dVal[6:0];
      ovrEEn    <= eEn;
      ovrEVal   <= eVal;
      ovrC1En   <= c1En;
      ovrC1Val  <= c1Val;
      captureIn <= steerQ[gps_pkg::SEL_M2_CAP] ? capSync2Q[1]
                                               : capSync2Q[0];
    end
  end

  AST_OE_FOLLOWS_DIR: assert property (
    (dirQ == 8'h00 && perAEn == 8'h00) [*2] |-> padAOe == 8'hff)
    else $error("Output enable does not follow cleared direction.");

  AST_PERIPH_OWNS_PIN: assert property (
    perAEn[0] && !perAVal[0] && latQ[0] |=> padAOe[0] && !padAOut[0])
    else $error("Latch drove a pin owned by a peripheral.");

  AST_ANALOG_READS_ZERO: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == gps_pkg::OFF_PIN
    |=> (s_axi_rdata[7:0] & $past(anselQ)) == 8'h00)
    else $error("Analog pin did not read as zero.");

  AST_ANSEL_UNIMPL: assert property (
    (anselQ & ~gps_pkg::ANSEL_IMP) == 8'h00)
    else $error("Unimplemented analog-select bit is set.");

  AST_LAT_READBACK: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == gps_pkg::OFF_LAT
    |=> s_axi_rvalid && s_axi_rdata == {24'h000000, $past(latQ)})
    else $error("Latch read did not return latch.");

  AST_PIN_WRITE_SAME: assert property (
    wrFire && wStrbQ[1:0] == 2'h1 &&
    (awAddrQ == gps_pkg::OFF_PIN || awAddrQ == gps_pkg::OFF_LAT)
    |=> latQ == $past(wDataQ[7:0]) ##1 s_axi_bvalid || !s_axi_bready)
    else $error("Port write did not land in the latch.");

  AST_RMW_MERGE: assert property (
    wrFire && wStrbQ[1:0] == 2'h3 && awAddrQ == gps_pkg::OFF_LAT
    |=> latQ == (($past(pinRead) & ~$past(wDataQ[15:8])) |
                 ($past(wDataQ[7:0]) & $past(wDataQ[15:8]))))
    else $error("Read-modify-write merge is wrong.");

  AST_STEER_M3C: assert property (
    steerQ[gps_pkg::SEL_M3_PWM_C] && funcOe[gps_pkg::SEL_M3_PWM_C]
    |=> ovrDEn[3] && !ovrEEn[3])
    else $error("Module 3 phase C not steered to port D.");

  AST_STEER_M1B: assert property (
    !steerQ[gps_pkg::SEL_M1_PWM_B] && funcOe[gps_pkg::SEL_M1_PWM_B]
    |=> ovrEEn[6] && !ovrDEn[6])
    else $error("Module 1 phase B not on port E.");

  AST_CAP_ROUTE: assert property (
    $stable(steerQ) [*3] |-> captureIn ==
      ($past(steerQ[gps_pkg::SEL_M2_CAP]) ? $past(capSync2Q[1])
                                          : $past(capSync2Q[0])))
    else $error("Capture input taken from the wrong pin.");

  AST_DIR_UNTOUCHED: assert property (
    wrFire && awAddrQ == gps_pkg::OFF_STEER |=> $stable(dirQ))
    else $error("Steering write changed direction.");

  CVR_WRITE_DONE: cover property (s_axi_bvalid && s_axi_bready);
  CVR_READ_DONE: cover property (s_axi_rvalid && s_axi_rready);
  CVR_STEER_D: cover property (ovrDEn != 7'h00);
  CVR_CAP_ALT: cover property (ovrEEn[7] && steerQ[2]);

endmodule

// file: testbench/gps_pad_model.sv
`timescale 1ns/10ps
module gps_pad_model
(
  input  wire logic       clk_sys,
  input  wire logic [7:0] padAOut,
  input  wire logic [7:0] padAOe,
  input  wire logic [7:0] weakPullupA,
  input  wire logic [7:0] extEn,
  input  wire logic [7:0] extVal,
  output logic [7:0]      padAIn
);
  logic [7:0] lastQ;

  always_ff @(posedge clk_sys)
  begin
    lastQ <= padAIn;
  end

  // A pin nobody drives or pulls wanders, so a stale level never passes.
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (padAOe[i]) padAIn[i] = padAOut[i];
      else if (extEn[i]) padAIn[i] = extVal[i];
      else if (weakPullupA[i]) padAIn[i] = 1'b1;
      else padAIn[i] = ~lastQ[i];
    end
  end
endmodule

// file: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  typedef struct {logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} gps_row_t;
  logic        clk_sys, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, padC1In, padE7In;
  logic        ovrC1En, ovrC1Val, captureIn;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]  s_axi_wstrb;
  logic [6:0]  ovrDEn, ovrDVal;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, padAIn, padAOut, padAOe;
  logic [7:0]  weakPullupA, analogSelA, perAEn, perAVal, funcOut, funcOe;
  logic [7:0]  ovrEEn, ovrEVal, extEn, extVal;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  int          mismatches = 0;
  int          comparisons = 0;
  int          pinOf [8] = '{6, 5, 7, 2, 1, 0, 4, 3};
  gps_row_t    rows [6] = '{
    '{gps_pkg::OFF_DIR, 32'h5a, 32'h5a, gps_pkg::RESP_OKAY},
    '{gps_pkg::OFF_LAT, 32'ha5, 32'ha5, gps_pkg::RESP_OKAY},
    '{gps_pkg::OFF_ANSEL, 32'hff, 32'h2f, gps_pkg::RESP_OKAY},
    '{gps_pkg::OFF_WPU, 32'h3c, 32'h3c, gps_pkg::RESP_OKAY},
    '{gps_pkg::OFF_STEER, 32'hff, 32'hff, gps_pkg::RESP_OKAY},
    '{8'h18, 32'hff, 32'h00, gps_pkg::RESP_SLVERR}};

  gps_port_top dut_u (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .padAIn, .padAOut, .padAOe, .weakPullupA, .analogSelA, .perAEn, .perAVal,
    .funcOut, .funcOe, .padC1In, .padE7In, .ovrDEn, .ovrDVal, .ovrEEn,
    .ovrEVal, .ovrC1En, .ovrC1Val, .captureIn);

  gps_pad_model board_u (.clk_sys, .padAOut, .padAOe, .weakPullupA, .extEn,
    .extVal, .padAIn);

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input string n, input logic [7:0] a,
                      input logic [31:0] e);
    rdr(a);
    chk(n, e, rd);
  endtask

  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  task automatic rstChk();
    rchk("dir", gps_pkg::OFF_DIR, 32'hff);
    rchk("lat", gps_pkg::OFF_LAT, 32'h00);
    rchk("ansel", gps_pkg::OFF_ANSEL, 32'h2f);
    rchk("wpu", gps_pkg::OFF_WPU, 32'h00);
    rchk("steer", gps_pkg::OFF_STEER, 32'h00);
    chk("ansel pins", 8'h2f, analogSelA);
  endtask

  task automatic steerChk(input logic [7:0] s);
    logic [7:0] eEn, eV;
    logic [6:0] dEn, dV;
    logic       cEn, cV;
    wr(gps_pkg::OFF_STEER, {24'h0, s}, 4'h1);
    settle();
    {eEn, eV, dEn, dV, cEn, cV} = '0;
    for (int b = 0; b < 8; b++)
    begin
      if (b == 2 && !s[b]) {cEn, cV} = {1'b1, funcOut[b]};
      else if (s[b] && b != 2)
        {dEn[pinOf[b]], dV[pinOf[b]]} = {1'b1, funcOut[b]};
      else {eEn[pinOf[b]], eV[pinOf[b]]} = {1'b1, funcOut[b]};
    end
    chk("e en", eEn, ovrEEn);
    chk("e val", eV, ovrEVal & eEn);
    chk("d en", dEn, ovrDEn);
    chk("d val", dV, ovrDVal & dEn);
    chk("c1", {cEn, cV}, {ovrC1En, ovrC1Val & cEn});
    chk("capture", !s[2], captureIn);
  endtask

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    conclude();
  end

  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    {s_axi_rready, perAEn, perAVal} = '0;
    {funcOut, funcOe, padC1In, padE7In} = {8'h96, 8'hff, 1'b1, 1'b0};
    {extEn, extVal} = {8'hff, 8'hff};
    rst_n = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rstChk();
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d, 4'h1);
      chk("bresp", rows[i].r, rsp);
      rdr(rows[i].a);
      chk("rresp", rows[i].r, rsp);
      chk("rdata", rows[i].e, rd);
    end
    chk("pullup", 8'h3c, weakPullupA);
    rchk("dir kept", gps_pkg::OFF_DIR, 32'h5a);
    wr(gps_pkg::OFF_DIR, 32'hff, 4'h1);
    settle();
    rchk("pin analog", gps_pkg::OFF_PIN, 32'hd0);
    wr(gps_pkg::OFF_DIR, 32'h00, 4'h1);
    wr(gps_pkg::OFF_LAT, 32'h3c, 4'h1);
    settle();
    chk("oe", 8'hff, padAOe);
    chk("out", 8'h3c, padAOut);
    rchk("pin drv", gps_pkg::OFF_PIN, 32'h10);
    wr(gps_pkg::OFF_ANSEL, 32'h00, 4'h1);
    wr(gps_pkg::OFF_PIN, 32'h81, 4'h1);
    rchk("lat via pin", gps_pkg::OFF_LAT, 32'h81);
    // Low nibble drives the latch, high nibble reads the board.
    wr(gps_pkg::OFF_DIR, 32'hf0, 4'h1);
    extVal <= 8'ha0;
    settle();
    rchk("pin mix", gps_pkg::OFF_PIN, 32'ha1);
    wr(gps_pkg::OFF_LAT, 32'h0202, 4'h3);
    rchk("rmw", gps_pkg::OFF_LAT, 32'ha3);
    perAEn <= 8'h01;
    settle();
    chk("per out", 8'ha2, padAOut);
    chk("per oe", 8'h0f, padAOe);
    rchk("per pin", gps_pkg::OFF_PIN, 32'ha2);
    perAEn <= 8'h00;
    steerChk(8'h00);
    steerChk(8'hff);
    steerChk(8'h55);
    rchk("dir steer", gps_pkg::OFF_DIR, 32'hf0);
    rst_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rstChk();
    conclude();
  end
endmodule
